// File: core/async_packet_pkg.sv
package async_packet_pkg;

    // ==========================================
    // Widths and storage
    localparam int ADDR_W     = 8;       // Register port address width
    localparam int QUAD_W     = 32;      // One quadlet
    localparam int FIFO_DEPTH = 32;      // Receive store depth in quadlets
    localparam int FIFO_AW    = 5;       // Index width of the store
    localparam int CNT_W      = 16;      // Quadlet counters within a packet
    localparam int IRQ_W      = 5;       // Number of event bits

    // ==========================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_TX_CTRL  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TX_BODY  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_TX_CHECK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_TX_GO    = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_RX_DATA  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_RX_STAT  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_NODE_CNT = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_INT_CLR  = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_INT_EN   = 8'h24;

    // ==========================================
    // Reset values
    localparam logic [31:0]      RST_QUAD = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] RST_IRQ  = 5'h00;
    localparam logic [5:0]       RST_NODE = 6'h00;

    // ==========================================
    // Event bit positions
    localparam int IRQ_RX_PKT  = 0;      // Packet plus status stored
    localparam int IRQ_RX_ERR  = 1;      // Status carried 0dh or 04h
    localparam int IRQ_TX_DONE = 2;      // Unformatted packet sent
    localparam int IRQ_TX_FMT  = 3;      // Unformatted packet refused
    localparam int IRQ_SELFID  = 4;      // Self-ID collection failed

    // ==========================================
    // Field positions
    localparam int SPD_LSB   = 16;       // Speed field, control/status
    localparam int TCODE_LSB = 4;        // Transaction code
    localparam int RT_LSB    = 8;        // Retry code
    localparam int BUS_LSB   = 22;       // Bus number of destination
    localparam int NODE_LSB  = 16;       // Node number of destination
    localparam int KIND_LSB  = 30;       // Unformatted packet identifier
    localparam int LEN_LSB   = 16;       // Data length in fourth quadlet

    // ==========================================
    // Codes
    localparam logic [3:0] TC_UNFMT     = 4'he;
    localparam logic [3:0] TC_WR_QUAD   = 4'h0;
    localparam logic [3:0] TC_WR_BLOCK  = 4'h1;
    localparam logic [3:0] TC_WR_RESP   = 4'h2;
    localparam logic [3:0] TC_RD_QUAD   = 4'h4;
    localparam logic [3:0] TC_RD_BLOCK  = 4'h5;
    localparam logic [3:0] TC_RESP_QUAD = 4'h6;
    localparam logic [3:0] TC_RESP_BLK  = 4'h7;
    localparam logic [3:0] TC_LOCK_REQ  = 4'h9;
    localparam logic [3:0] TC_LOCK_RESP = 4'hb;
    localparam logic [1:0] KIND_CONFIG  = 2'b00;
    localparam logic [1:0] KIND_LINKON  = 2'b01;
    localparam logic [1:0] RT_FIRST     = 2'b00;
    localparam logic [1:0] SPD_RSVD     = 2'b11;
    localparam logic [3:0] ACK_DATA_ERR = 4'hd;
    localparam logic [3:0] ACK_FULL     = 4'h4;
    localparam logic [9:0] BUS_LOCAL    = 10'h000;
    localparam logic [5:0] NODE_BCAST   = 6'h3f;
    localparam logic [5:0] NODE_MAX     = 6'h3f;
    localparam logic [2:0] HDR_NODATA   = 3'd3;
    localparam logic [2:0] HDR_QUAD     = 3'd4;

endpackage

// File: core/rx_store_if.sv
`timescale 1ns/100ps
// Write side and read side of the receive store
interface rx_store_if;
    logic                                  push;      // Write one quadlet
    logic [async_packet_pkg::QUAD_W-1:0]   push_data; // Quadlet written
    logic                                  full;      // No room left
    logic                                  pop;       // Drop the head
    logic [async_packet_pkg::QUAD_W-1:0]   head;      // Oldest quadlet
    logic                                  empty;     // Nothing stored
    logic [async_packet_pkg::FIFO_AW:0]    level;     // Quadlets stored
    modport user  (output push, push_data, pop,
                   input  full, head, empty, level);
    modport store (input  push, push_data, pop,
                   output full, head, empty, level);
endinterface

// File: core/async_receive_fifo.sv
`timescale 1ns/100ps
module async_receive_fifo (
    input  logic   clk,
    input  logic   reset,
    rx_store_if.store port
);
    import async_packet_pkg::*;

    // ==========================================
    // Storage
    logic [QUAD_W-1:0]  mem [FIFO_DEPTH];  // Quadlet cells
    logic [FIFO_AW-1:0] wr_reg;            // Next cell to write
    logic [FIFO_AW-1:0] rd_reg;            // Cell at the head
    logic [FIFO_AW:0]   level_reg;         // Quadlets held
    logic               do_push;           // Write accepted
    logic               do_pop;            // Read accepted

    assign do_push    = port.push && !port.full;
    assign do_pop     = port.pop && !port.empty;
    assign port.full  = (level_reg == (FIFO_AW+1)'(FIFO_DEPTH));
    assign port.empty = (level_reg == '0);
    assign port.head  = mem[rd_reg];
    assign port.level = level_reg;

    // Cell writes, no reset needed on data
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_reg] <= port.push_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_reg    <= '0;
            rd_reg    <= '0;
            level_reg <= '0;
        end else begin
            if (do_push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            // Simultaneous push and pop leave the level alone
            if (do_push && !do_pop) begin
                level_reg <= level_reg + 1'b1;
            end else if (do_pop && !do_push) begin
                level_reg <= level_reg - 1'b1;
            end
        end
    end

endmodule

// File: core/async_packet_format.sv
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
module async_packet_format (
    input  logic                                clk,
    input  logic                                reset,
    input  logic [async_packet_pkg::ADDR_W-1:0] addr,
    input  logic [31:0]                         wdata,
    input  logic                                wr,
    input  logic                                rd,
    output logic [31:0]                         rdata,
    output logic                                irq,
    output logic                                tx_valid,
    output logic [31:0]                         tx_data,
    output logic                                tx_last,
    input  logic                                tx_ready,
    input  logic                                rx_valid,
    input  logic [31:0]                         rx_data,
    input  logic                                rx_last,
    input  logic [1:0]                          rx_spd,
    input  logic [3:0]                          rx_ack,
    input  logic                                rx_crc_err,
    input  logic                                bus_reset,
    input  logic                                selfid_valid,
    input  logic                                selfid_error
);
    import async_packet_pkg::*;

    // ==========================================
    // Helpers

    // Header quadlets stored ahead of any data
    function automatic logic [2:0] hdr_quads(input logic [3:0] tc);
        unique case (tc)
            TC_RD_QUAD, TC_WR_RESP: hdr_quads = HDR_NODATA;
            default:                hdr_quads = HDR_QUAD;
        endcase
    endfunction

    // Block class codes carry data after the fourth quadlet
    function automatic logic is_block(input logic [3:0] tc);
        is_block = (tc == TC_WR_BLOCK) || (tc == TC_RESP_BLK) ||
                   (tc == TC_LOCK_REQ) || (tc == TC_LOCK_RESP);
    endfunction

    // Byte count rounded up to quadlets
    function automatic logic [CNT_W-1:0] quad_count(input logic [15:0] n);
        logic [16:0] sum;
        sum        = {1'b0, n} + 17'd3;
        quad_count = CNT_W'(sum[16:2]);
    endfunction

    // ==========================================
    // Register file state
    logic [1:0]       tx_spd_reg;     // Transmit speed
    logic [3:0]       tx_prio_reg;    // Transmit priority
    logic [31:0]      tx_body_reg;    // Second quadlet
    logic [31:0]      tx_check_reg;   // Third quadlet, host inverted
    logic [IRQ_W-1:0] int_stat_reg;   // Sticky events
    logic [IRQ_W-1:0] int_en_reg;     // Event enables
    logic [IRQ_W-1:0] ev;             // Events this cycle
    logic [5:0]       node_cnt_reg;   // Self-ID packets counted
    logic             collect_reg;    // Self-ID collection open
    logic             sid_fail_reg;   // Collection aborted
    logic             last_bcast_reg; // Last packet was broadcast
    logic             last_local_reg; // Last packet was local bus
    logic [1:0]       last_rt_reg;    // Retry code of last packet
    logic             last_retry_reg; // Last packet was a retry
    logic [1:0]       last_kind_reg;  // Kind of last transmit

    // Decoded strobes
    logic wr_go;                      // Transmit start request
    logic rd_pop;                     // Receive store read

    assign wr_go  = wr && (addr == OFS_TX_GO);
    assign rd_pop = rd && (addr == OFS_RX_DATA);

    // Receive store
    rx_store_if store_bus ();

    async_receive_fifo u_store (
        .clk   (clk),
        .reset (reset),
        .port  (store_bus)
    );

    assign store_bus.pop = rd_pop;

    // ==========================================
    // Software writable registers
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_spd_reg   <= '0;
            tx_prio_reg  <= '0;
            tx_body_reg  <= RST_QUAD;
            tx_check_reg <= RST_QUAD;
            int_en_reg   <= RST_IRQ;
        end else if (wr) begin
            unique case (addr)
                OFS_TX_CTRL: begin
                    tx_spd_reg  <= wdata[SPD_LSB+:2];
                    tx_prio_reg <= wdata[3:0];
                end
                OFS_TX_BODY:  tx_body_reg  <= wdata;
                OFS_TX_CHECK: tx_check_reg <= wdata;
                OFS_INT_EN:   int_en_reg   <= wdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================
    // Transmit of unformatted packets
    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_CTRL  = 4'b0010,
        TX_BODY  = 4'b0100,
        TX_CHECK = 4'b1000
    } tx_state_t;

    tx_state_t tx_state_reg;          // Current transmit step
    logic      tx_ok;                 // Body has a legal layout
    logic [1:0] tx_kind;              // Identifier bits of body

    assign tx_kind = tx_body_reg[KIND_LSB+:2];
    // Config needs kind 00; link-on needs kind 01 and zero tail
    assign tx_ok = (tx_kind == KIND_CONFIG) ||
                   ((tx_kind == KIND_LINKON) &&
                    (tx_body_reg[23:0] == 24'h000000));
    assign tx_valid = (tx_state_reg != TX_IDLE);
    assign tx_last  = (tx_state_reg == TX_CHECK);

    // Quadlet sequencer, body words leave unchanged
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_state_reg  <= TX_IDLE;
            tx_data       <= RST_QUAD;
            last_kind_reg <= '0;
        end else begin
            unique case (tx_state_reg)
                TX_IDLE: begin
                    // A start while busy is simply ignored
                    if (wr_go && wdata[0] && tx_ok) begin
                        tx_state_reg  <= TX_CTRL;
                        last_kind_reg <= tx_kind;
                        // Control quadlet, nothing appended later
                        tx_data <= {14'h0000, tx_spd_reg, 8'h00,
                                    TC_UNFMT, tx_prio_reg};
                    end
                end
                TX_CTRL: begin
                    if (tx_ready) begin
                        tx_state_reg <= TX_BODY;
                        // Root, gap bits travel as written
                        tx_data      <= tx_body_reg;
                    end
                end
                TX_BODY: begin
                    if (tx_ready) begin
                        tx_state_reg <= TX_CHECK;
                        tx_data      <= tx_check_reg;
                    end
                end
                TX_CHECK: begin
                    // No CRC word follows the check quadlet
                    if (tx_ready) begin
                        tx_state_reg <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // Receive formatting
    typedef enum logic [1:0] {
        RX_COLLECT = 2'b01,
        RX_STATUS  = 2'b10
    } rx_state_t;

    rx_state_t        rx_state_reg;   // Collecting or status pending
    logic [CNT_W-1:0] rx_idx_reg;     // Quadlet index in packet
    logic [2:0]       hdr_reg;        // Header quadlets of packet
    logic [3:0]       tc_reg;         // Transaction code of packet
    logic [CNT_W-1:0] dq_reg;         // Data quadlets of packet
    logic             ovf_reg;        // Quadlet dropped in packet
    logic [31:0]      status_reg;     // Pending status quadlet
    logic [2:0]       cur_hdr;        // Header length in effect
    logic [CNT_W-1:0] cur_dq;         // Data length in effect
    logic [CNT_W-1:0] total;          // Quadlets expected to store
    logic [CNT_W-1:0] seen;           // Quadlets received so far
    logic             want;           // Quadlet belongs in store
    logic             rx_push;        // Stream quadlet written
    logic             drop;           // Stream quadlet lost
    logic             st_push;        // Status quadlet written
    logic [3:0]       ack_out;        // Ack code put in status

    always_comb begin
        cur_hdr = hdr_reg;
        cur_dq  = dq_reg;
        if (rx_idx_reg == '0) begin
            cur_hdr = hdr_quads(rx_data[TCODE_LSB+:4]);
            cur_dq  = '0;
        end else if ((rx_idx_reg == CNT_W'(3)) && is_block(tc_reg)) begin
            // Zero length gives zero data quadlets
            cur_dq = quad_count(rx_data[LEN_LSB+:16]);
        end
    end

    assign total   = CNT_W'(cur_hdr) + cur_dq;
    assign seen    = rx_idx_reg + 1'b1;
    // Header then data words; surplus quadlets never stored
    assign want    = rx_valid && (rx_idx_reg < total);
    assign st_push = (rx_state_reg == RX_STATUS) && !store_bus.full;
    assign rx_push = want && !st_push && !store_bus.full;
    assign drop    = want && !rx_push;

    // Data quadlets pass as received, first byte in [31:24]
    assign store_bus.push      = rx_push || st_push;
    assign store_bus.push_data = st_push ? status_reg : rx_data;

    // Link ack, or own code for length, CRC or overflow trouble
    always_comb begin
        if (ovf_reg || drop) begin
            ack_out = ACK_FULL;
        end else if (rx_crc_err || (seen != total)) begin
            ack_out = ACK_DATA_ERR;
        end else begin
            ack_out = rx_ack;
        end
    end

    // Packet walker and status builder
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_state_reg <= RX_COLLECT;
            rx_idx_reg   <= '0;
            hdr_reg      <= HDR_QUAD;
            tc_reg       <= '0;
            dq_reg       <= '0;
            ovf_reg      <= 1'b0;
            status_reg   <= RST_QUAD;
        end else begin
            if (st_push) begin
                rx_state_reg <= RX_COLLECT;
            end
            if (rx_valid) begin
                hdr_reg <= cur_hdr;
                dq_reg  <= cur_dq;
                if (rx_idx_reg == '0) begin
                    tc_reg <= rx_data[TCODE_LSB+:4];
                end
                if (rx_last) begin
                    rx_idx_reg   <= '0;
                    ovf_reg      <= 1'b0;
                    rx_state_reg <= RX_STATUS;
                    // Speed code kept as received, 11 included
                    status_reg <= {14'h0000, rx_spd, 12'h000,
                                   ack_out};
                end else begin
                    rx_idx_reg <= seen;
                    if (drop) begin
                        ovf_reg <= 1'b1;
                    end
                end
            end
        end
    end

    // Destination and retry of each new header
    always_ff @(posedge clk) begin
        if (reset) begin
            last_bcast_reg <= 1'b0;
            last_local_reg <= 1'b0;
            last_rt_reg    <= RT_FIRST;
            last_retry_reg <= 1'b0;
        end else if (rx_valid && (rx_idx_reg == '0)) begin
            last_local_reg <= (rx_data[BUS_LSB+:10] == BUS_LOCAL);
            last_bcast_reg <= (rx_data[NODE_LSB+:6] == NODE_BCAST);
            last_rt_reg    <= rx_data[RT_LSB+:2];
            last_retry_reg <= (rx_data[RT_LSB+:2] != RT_FIRST);
        end
    end

    // ==========================================
    // Self-ID collection
    always_ff @(posedge clk) begin
        if (reset) begin
            node_cnt_reg <= RST_NODE;
            collect_reg  <= 1'b0;
            sid_fail_reg <= 1'b0;
        end else if (bus_reset) begin
            node_cnt_reg <= RST_NODE;
            collect_reg  <= 1'b1;
            sid_fail_reg <= 1'b0;
        end else if (collect_reg && selfid_error) begin
            // Abort at once so software sees a zero count
            node_cnt_reg <= RST_NODE;
            collect_reg  <= 1'b0;
            sid_fail_reg <= 1'b1;
        end else if (collect_reg && selfid_valid &&
                     (node_cnt_reg != NODE_MAX)) begin
            node_cnt_reg <= node_cnt_reg + 1'b1;
        end
    end

    // ==========================================
    // Events and interrupt
    always_comb begin
        ev              = '0;
        ev[IRQ_RX_PKT]  = st_push;
        ev[IRQ_RX_ERR]  = st_push &&
                          ((status_reg[3:0] == ACK_DATA_ERR) ||
                           (status_reg[3:0] == ACK_FULL));
        ev[IRQ_TX_DONE] = (tx_state_reg == TX_CHECK) && tx_ready;
        ev[IRQ_TX_FMT]  = (tx_state_reg == TX_IDLE) && wr_go &&
                          wdata[0] && !tx_ok;
        ev[IRQ_SELFID]  = collect_reg && selfid_error && !bus_reset;
    end

    // Sticky bits, a new event beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            int_stat_reg <= RST_IRQ;
        end else begin
            if (wr && (addr == OFS_INT_CLR)) begin
                int_stat_reg <= (int_stat_reg & ~wdata[IRQ_W-1:0]) | ev;
            end else begin
                int_stat_reg <= int_stat_reg | ev;
            end
        end
    end

    assign irq = |(int_stat_reg & int_en_reg);

    // ==========================================
    // Read data, valid the cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= RST_QUAD;
        end else if (rd) begin
            unique case (addr)
                OFS_TX_CTRL:  rdata <= {14'h0000, tx_spd_reg, 12'h000,
                                        tx_prio_reg};
                OFS_TX_BODY:  rdata <= tx_body_reg;
                OFS_TX_CHECK: rdata <= tx_check_reg;
                OFS_TX_GO:    rdata <= {28'h0000000, last_kind_reg,
                                        1'b0, tx_valid};
                // Reading an empty store returns zero
                OFS_RX_DATA:  rdata <= store_bus.empty ? RST_QUAD
                                                       : store_bus.head;
                OFS_RX_STAT:  rdata <= {11'h000, last_retry_reg,
                                        last_rt_reg, last_local_reg,
                                        last_bcast_reg, 7'h00,
                                        store_bus.level,
                                        1'b0, store_bus.full,
                                        store_bus.empty};
                OFS_NODE_CNT: rdata <= {22'h000000, collect_reg,
                                        sid_fail_reg, 2'b00,
                                        node_cnt_reg};
                OFS_INT_STAT: rdata <= {27'h0000000, int_stat_reg};
                OFS_INT_EN:   rdata <= {27'h0000000, int_en_reg};
                default:      rdata <= RST_QUAD;
            endcase
        end
    end

endmodule

// File: bench/async_packet_format_properties.sv
`timescale 1ns/100ps
module format_properties (
    input logic        clk,
    input logic        reset,
    input logic [7:0]  addr,
    input logic        rd,
    input logic [31:0] rdata,
    input logic        tx_valid,
    input logic [31:0] tx_data,
    input logic        tx_last,
    input logic        tx_ready,
    input logic        bus_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_code; $rose(tx_valid) |-> tx_data[7:4] == 4'he; endproperty
    a_code: assert property (p_code) else $error("code");
    property p_kind; $rose(tx_valid) && tx_ready |=>
        !tx_data[31] && (!tx_data[30] || !tx_data[23:0]); endproperty
    a_kind: assert property (p_kind) else $error("kind");
    property p_len; $rose(tx_valid) && tx_ready |=> !tx_last; endproperty
    a_len: assert property (p_len) else $error("length");
    property p_hold; tx_valid && !tx_ready |=> $stable(tx_data); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_end; tx_last && tx_ready |=> !tx_valid; endproperty
    a_end: assert property (p_end) else $error("end");
    property p_gap; rd && addr == 8'h28 |=> rdata == 32'h0; endproperty
    a_gap: assert property (p_gap) else $error("unmapped");
    property p_idle; rd && addr == 8'h18 |=> rdata[9] || !rdata[5:0];
    endproperty
    a_idle: assert property (p_idle) else $error("count");
    property p_open; bus_reset ##1 rd && addr == 8'h18 |=>
        rdata[9] && !rdata[5:0]; endproperty
    a_open: assert property (p_open) else $error("open");
endmodule
bind async_packet_format format_properties props (.*);

// File: bench/phy_model.sv
`timescale 1ns/100ps
module phy_model (
    input  logic clk,
    input  logic slow,
    input  logic tx_valid,
    output logic tx_ready
);
    logic stall_reg = 1'b0; // Slow line side takes every other cycle
    always @(posedge clk) stall_reg <= tx_valid & ~stall_reg;
    assign tx_ready = ~slow | stall_reg;
endmodule

// File: bench/test_async_packet_format.sv
`timescale 1ns/100ps
module test_async_packet_format;
    logic clk = 0, reset = 1, wr = 0, rd = 0, slow = 0, rx_valid = 0;
    logic rx_last = 0, rx_crc_err = 0, bus_reset = 0, selfid_valid = 0;
    logic selfid_error = 0, irq, tx_valid, tx_ready, tx_last;
    logic [7:0] addr = 0;
    logic [1:0] rx_spd = 0;
    logic [3:0] rx_ack = 0;
    logic [31:0] wdata = 0, rx_data = 0, rdata, tx_data, pk[$], txq[$];
    int n_errors = 0, comparisons = 0;
    always #25 clk = ~clk;
    async_packet_format uut (.*);
    phy_model phy (.*);
    always @(posedge clk) if (tx_valid && tx_ready) txq.push_back(tx_data);
    task automatic chk(logic [31:0] got, exp);
        comparisons++;
        n_errors += int'(got !== exp);
        if (got !== exp) $display("Error %0t: %h %h", $time, got, exp);
    endtask
    // One register access, then an idle cycle
    task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
        {addr, wdata, wr, rd} <= {a, d, w, !w};
        @(posedge clk) {wr, rd} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic rc(logic [7:0] a, logic [31:0] m, e);
        acc(0, a, 0);
        chk(rdata & m, e);
    endtask
    task automatic rx_run(logic [1:0] s, logic c, logic [31:0] st);
        foreach (pk[i]) begin
            {rx_valid, rx_data, rx_last} <= {1'b1, pk[i], i == pk.size() - 1};
            {rx_spd, rx_ack, rx_crc_err} <= {s, 2'b10, s, c};
            @(posedge clk);
        end
        {rx_valid, rx_last} <= 2'b00;
        @(posedge clk);
        foreach (pk[i])
            if (i < async_packet_pkg::FIFO_DEPTH)
                rc(8'h10, '1, pk[i]);
        rc(8'h10, '1, st);
    endtask
    task automatic tx_run(logic [31:0] b, logic ok);
        txq.delete();
        slow <= ~b[30];
        acc(1, 8'h04, b);
        acc(1, 8'h08, ~b);
        acc(1, 8'h0c, 32'h1);
        for (int k = 0; k < 20 && txq.size() < 3; k++) @(posedge clk);
        chk(txq.size(), ok ? 3 : 0);
        foreach (txq[i]) chk(txq[i], i ? (i > 1 ? ~b : b) : 32'h1_00e3);
    endtask
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        reset <= 0;
        rc(8'h1c, '1, 0);
        rc(8'h28, '1, 0);
        acc(1, 8'h24, 32'h1f);
        acc(1, 8'h00, 32'h1_0003);
        tx_run(32'h05c3_0000, 1);
        tx_run(32'h4500_0001, 0);
        tx_run(32'h4500_0000, 1);
        rc(8'h1c, '1, 32'hc);
        chk(irq, 1);
        acc(1, 8'h20, 32'h1f);
        $display("Transmit tests done");
        for (int i = 0; i < 4; i++) begin
            pk = '{{16'h3f, 6'h0, 2'(i), 8'h40}, 32'h1234_ffff, 32'h5678};
            rx_run(2'(i), 0, {14'h0, 2'(i), 14'h2, 2'(i)});
            rc(8'h14, 32'h1f0001, {11'h0, i > 0, 2'(i), 18'h30001});
        end
        pk = '{32'h10, 32'h0, 0, 0};
        rx_run(2'b01, 0, 32'h1_0009);
        pk = '{32'h10, 32'h0, 0, 32'h5_0000, 32'h0102_0304, 32'h0500_0000};
        rx_run(2'b10, 1, 32'h2_000d);
        rc(8'h1c, 32'h3, 32'h3);
        // Oversized block: the store fills, the tail is dropped
        pk = '{32'h10, 32'h0, 0, 32'h80_0000};
        for (int i = 0; i < 32; i++) pk.push_back(i);
        rx_run(2'b00, 0, 32'h4);
        $display("Receive tests done");
        bus_reset <= 1;
        @(posedge clk) bus_reset <= 0;
        rc(8'h18, 32'h23f, 32'h200);
        selfid_valid <= 1;
        repeat (2) @(posedge clk);
        selfid_valid <= 0;
        rc(8'h18, 32'h23f, 32'h202);
        selfid_error <= 1;
        @(posedge clk) selfid_error <= 0;
        rc(8'h18, 32'h33f, 32'h100);
        rc(8'h1c, 32'h10, 32'h10);
        $display("Self-ID tests done");
        acc(1, 8'h24, 0);
        chk(irq, 0);
        final_report;
    end
endmodule
